// File: src/blc_pkg.sv
// Purpose: shared types and constants for the bipolar line codec
// Assumes: one 20 MHz system clock, line bits paced by enable strobes
// Notes: nominal rates are kept for status reporting only
package blc_pkg;

  // ==========================================================
  // modes and symbols
  typedef enum logic [2:0] {
    BLC_MODE_E1_HDB3,
    BLC_MODE_T1_B8ZS,
    BLC_MODE_T1_AMI,
    BLC_MODE_E3_HDB3,
    BLC_MODE_T3_B3ZS
  } blc_mode_t;

  typedef enum logic [1:0] {
    BLC_SYM_ZERO,
    BLC_SYM_MARK,
    BLC_SYM_VIOL
  } blc_sym_t;

  // one bipolar line interval: positive rail, negative rail
  typedef struct packed {
    logic pos;
    logic neg;
  } blc_line_t;

  // one received interval held in the decoder window
  typedef struct packed {
    logic pos;
    logic neg;
    logic viol;
  } blc_slot_t;

  // ==========================================================
  // window lengths (zero-run lengths that trigger substitution)
  localparam int unsigned BLC_WIN_MAX = 8;
  localparam logic [3:0] BLC_RUN_HDB3 = 4'h4;
  localparam logic [3:0] BLC_RUN_B8ZS = 4'h8;
  localparam logic [3:0] BLC_RUN_B3ZS = 4'h3;
  localparam logic [3:0] BLC_RUN_AMI = 4'h1;
  localparam logic [3:0] BLC_RUN_MAX = 4'hF;
  // longest legal zero run on the line for each code
  localparam logic [3:0] BLC_ZMAX_HDB3 = 4'h3;
  localparam logic [3:0] BLC_ZMAX_B8ZS = 4'h7;
  localparam logic [3:0] BLC_ZMAX_B3ZS = 4'h2;

  // ==========================================================
  // nominal tributary rates in kbit/s
  localparam logic [15:0] BLC_RATE_E1_KBPS = 16'h0800;
  localparam logic [15:0] BLC_RATE_T1_KBPS = 16'h0608;
  localparam logic [15:0] BLC_RATE_E3_KBPS = 16'h8640;
  localparam logic [15:0] BLC_RATE_T3_KBPS = 16'hAEC0;
  localparam logic [15:0] BLC_RATE_NONE = 16'h0000;

  // window length for a mode; plain AMI uses a single slot
  function automatic logic [3:0] blc_run_len(input blc_mode_t m);
    logic [3:0] r;
    r = BLC_RUN_AMI;
    unique case (m)
      BLC_MODE_E1_HDB3, BLC_MODE_E3_HDB3: r = BLC_RUN_HDB3;
      BLC_MODE_T1_B8ZS: r = BLC_RUN_B8ZS;
      BLC_MODE_T3_B3ZS: r = BLC_RUN_B3ZS;
      default: r = BLC_RUN_AMI;
    endcase
    return r;
  endfunction

endpackage

// File: src/blc_encoder.sv
// Purpose: AMI / HDB3 / B8ZS / B3ZS encoder for one tributary
// Assumes: one data bit per bit_en strobe, mode held static while running
// Notes: delay of run length minus one strobes so a zero run can be rewritten
`timescale 1ns/1ns
`default_nettype none

module blc_encoder (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire blc_pkg::blc_mode_t mode,
  // tributary side
  input wire logic bit_en,
  input wire logic bit_in,
  // line side
  output blc_pkg::blc_line_t line_q
);

  // ==========================================================
  // state
  blc_pkg::blc_sym_t [blc_pkg::BLC_WIN_MAX-1:0] sr_q, sr_d;
  logic [3:0] zc_q, zc_d;
  logic par_q, par_d;
  logic pol_q, pol_d;
  blc_pkg::blc_line_t line_d;
  logic [3:0] len;
  logic [2:0] idx;
  logic sub_en;
  blc_pkg::blc_sym_t out_sym;

  // ==========================================================
  // next state
  always_comb begin
    sr_d = sr_q;
    zc_d = zc_q;
    par_d = par_q;
    pol_d = pol_q;
    line_d = line_q;
    len = blc_pkg::blc_run_len(mode);
    idx = 3'(len - 4'h1);
    sub_en = (mode != blc_pkg::BLC_MODE_T1_AMI);
    out_sym = blc_pkg::BLC_SYM_ZERO;
    if (bit_en) begin
      for (int i = blc_pkg::BLC_WIN_MAX - 1; i > 0; i--) begin
        sr_d[i] = sr_q[i-1];
      end
      sr_d[0] = bit_in ? blc_pkg::BLC_SYM_MARK : blc_pkg::BLC_SYM_ZERO;
      if (bit_in) begin
        zc_d = 4'h0;
        par_d = ~par_q;
      end else if (sub_en && zc_q == idx) begin
        // run complete: write the substitution pattern into the window, count restarts after V
        zc_d = 4'h0;
        par_d = 1'b0;
        unique case (mode)
          blc_pkg::BLC_MODE_T1_B8ZS: begin
            sr_d[4] = blc_pkg::BLC_SYM_VIOL;
            sr_d[3] = blc_pkg::BLC_SYM_MARK;
            sr_d[1] = blc_pkg::BLC_SYM_VIOL;
            sr_d[0] = blc_pkg::BLC_SYM_MARK;
          end
          blc_pkg::BLC_MODE_T3_B3ZS: begin
            sr_d[0] = blc_pkg::BLC_SYM_VIOL;
            if (!par_q) begin
              sr_d[2] = blc_pkg::BLC_SYM_MARK;
            end
          end
          default: begin
            sr_d[0] = blc_pkg::BLC_SYM_VIOL;
            if (!par_q) begin
              sr_d[3] = blc_pkg::BLC_SYM_MARK;
            end
          end
        endcase
      end else if (zc_q != blc_pkg::BLC_RUN_MAX) begin
        zc_d = zc_q + 4'h1;
      end
      out_sym = sr_d[idx];
      // alternate on marks, repeat last polarity on violations
      unique case (out_sym)
        blc_pkg::BLC_SYM_MARK: begin
          line_d = '{pos: ~pol_q, neg: pol_q};
          pol_d = ~pol_q;
        end
        blc_pkg::BLC_SYM_VIOL: line_d = '{pos: pol_q, neg: ~pol_q};
        default: line_d = '{pos: 1'b0, neg: 1'b0};
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sr_q <= '{default: blc_pkg::BLC_SYM_ZERO};
      zc_q <= 4'h0;
      par_q <= 1'b0;
      pol_q <= 1'b0;
      line_q <= '{pos: 1'b0, neg: 1'b0};
    end else if (ce) begin
      sr_q <= sr_d;
      zc_q <= zc_d;
      par_q <= par_d;
      pol_q <= pol_d;
      line_q <= line_d;
    end
  end

endmodule // blc_encoder

`default_nettype wire

// File: src/blc_line_codec.sv
// Purpose: bipolar line codec top: encoder, decoder, violation counting
// Assumes: line bits paced by tx/rx enable strobes on the 20 MHz clock
// Notes: mode must be held static; change it only under reset
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - E1 mode codes the line with HDB3 at nominal 2.048 Mbit/s.
// - AMI: each one is a pulse of alternating polarity, zero is no pulse.
// - HDB3 transmit never sends more than three zero intervals in a row once its first pulse after reset is out.
// - every substitution carries a violation, a pulse repeating last polarity.
// - decoder finds violations and turns valid substitutions back into zeros.
// - violations outside valid substitutions are counted as line errors.
// - T1 mode runs at nominal 1.544 Mbit/s on an AMI base code.
// - T1 B8ZS mode lets any user data pass, full 64 kbit/s slots; T1 AMI mode does not.
// - E3 mode codes the line with HDB3 at nominal 34.368 Mbit/s.
// - T3 mode uses B3ZS at 44.736 Mbit/s, at most two zeros in a row once the first pulse after reset is out.
// - tributaries pass unframed and bit transparent, no frame search.
module blc_line_codec #(
  parameter int unsigned CNT_W = 16
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // configuration
  input wire blc_pkg::blc_mode_t mode,
  output logic [15:0] rate_kbps_q,
  // transmit tributary and line
  input wire logic tx_bit_en,
  input wire logic tx_bit,
  output blc_pkg::blc_line_t line_tx_q,
  // receive line and tributary
  input wire logic rx_bit_en,
  input wire blc_pkg::blc_line_t line_rx,
  output logic rx_bit_q,
  output logic rx_valid_q,
  // link quality
  input wire logic err_clr,
  output logic [CNT_W-1:0] err_count_q,
  output logic err_pulse_q,
  output logic zero_run_err_q
);

  // ==========================================================
  // elaboration check
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must lie between 2 and 32");
  end

  // ==========================================================
  // transmit path
  blc_encoder u_encoder (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .mode(mode),
    .bit_en(tx_bit_en),
    .bit_in(tx_bit),
    .line_q(line_tx_q)
  );

  // ==========================================================
  // nominal rate report
  logic [15:0] rate_d;

  always_comb begin
    rate_d = blc_pkg::BLC_RATE_NONE;
    unique case (mode)
      blc_pkg::BLC_MODE_E1_HDB3: rate_d = blc_pkg::BLC_RATE_E1_KBPS;
      blc_pkg::BLC_MODE_T1_B8ZS, blc_pkg::BLC_MODE_T1_AMI: rate_d = blc_pkg::BLC_RATE_T1_KBPS;
      blc_pkg::BLC_MODE_E3_HDB3: rate_d = blc_pkg::BLC_RATE_E3_KBPS;
      blc_pkg::BLC_MODE_T3_B3ZS: rate_d = blc_pkg::BLC_RATE_T3_KBPS;
      default: rate_d = blc_pkg::BLC_RATE_NONE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rate_kbps_q <= blc_pkg::BLC_RATE_NONE;
    end else if (ce) begin
      rate_kbps_q <= rate_d;
    end
  end

  // ==========================================================
  // receive window
  // the window is as long as the longest substitution, so a violation
  // is only judged once the whole pattern around it has arrived
  blc_pkg::blc_slot_t [blc_pkg::BLC_WIN_MAX-1:0] rs_q, rs_d;
  logic rpol_q, rpol_d;
  logic rseen_q, rseen_d;
  logic [3:0] rzc_q, rzc_d;
  logic rx_bit_d;
  logic rx_valid_d;
  logic err_pulse_d;
  logic zero_run_err_d;
  logic [3:0] rlen;
  logic [2:0] ridx;
  logic [3:0] zmax;
  logic pulse;
  logic dual;
  logic viol;
  logic sub_hit;
  blc_pkg::blc_slot_t out_slot;

  // true when a slot holds no pulse at all
  function automatic logic slot_zero(input blc_pkg::blc_slot_t s);
    return !(s.pos || s.neg);
  endfunction

  always_comb begin
    rs_d = rs_q;
    rpol_d = rpol_q;
    rseen_d = rseen_q;
    rzc_d = rzc_q;
    rx_bit_d = rx_bit_q;
    rx_valid_d = 1'b0;
    err_pulse_d = 1'b0;
    zero_run_err_d = 1'b0;
    rlen = blc_pkg::blc_run_len(mode);
    ridx = 3'(rlen - 4'h1);
    zmax = blc_pkg::BLC_RUN_MAX;
    pulse = line_rx.pos ^ line_rx.neg;
    dual = line_rx.pos & line_rx.neg;
    viol = 1'b0;
    sub_hit = 1'b0;
    out_slot = '{pos: 1'b0, neg: 1'b0, viol: 1'b0};
    unique case (mode)
      blc_pkg::BLC_MODE_E1_HDB3, blc_pkg::BLC_MODE_E3_HDB3: zmax = blc_pkg::BLC_ZMAX_HDB3;
      blc_pkg::BLC_MODE_T1_B8ZS: zmax = blc_pkg::BLC_ZMAX_B8ZS;
      blc_pkg::BLC_MODE_T3_B3ZS: zmax = blc_pkg::BLC_ZMAX_B3ZS;
      default: zmax = blc_pkg::BLC_RUN_MAX;
    endcase
    if (rx_bit_en) begin
      // a pulse repeating the last polarity breaks alternation
      viol = pulse && rseen_q && (line_rx.pos == rpol_q);
      if (pulse) begin
        rpol_d = line_rx.pos;
        rseen_d = 1'b1;
      end
      for (int i = blc_pkg::BLC_WIN_MAX - 1; i > 0; i--) begin
        rs_d[i] = rs_q[i-1];
      end
      // both rails at once is an illegal symbol: data zero, counted
      rs_d[0] = '{pos: pulse & line_rx.pos, neg: pulse & line_rx.neg, viol: viol | dual};
      // look for a complete substitution ending at the newest slot
      unique case (mode)
        blc_pkg::BLC_MODE_E1_HDB3, blc_pkg::BLC_MODE_E3_HDB3: begin
          sub_hit = viol && slot_zero(rs_d[1]) && slot_zero(rs_d[2]);
        end
        blc_pkg::BLC_MODE_T3_B3ZS: begin
          sub_hit = viol && slot_zero(rs_d[1]);
        end
        blc_pkg::BLC_MODE_T1_B8ZS: begin
          sub_hit = slot_zero(rs_d[7]) && slot_zero(rs_d[6]) && slot_zero(rs_d[5])
            && !slot_zero(rs_d[4]) && rs_d[4].viol
            && !slot_zero(rs_d[3]) && (rs_d[3].pos != rs_d[4].pos)
            && slot_zero(rs_d[2])
            && !slot_zero(rs_d[1]) && rs_d[1].viol && (rs_d[1].pos == rs_d[3].pos)
            && !slot_zero(rs_d[0]) && (rs_d[0].pos == rs_d[4].pos);
        end
        default: sub_hit = 1'b0;
      endcase
      if (sub_hit) begin
        // restore the original zeros and drop the intended violations
        for (int i = 0; i < blc_pkg::BLC_WIN_MAX; i++) begin
          if (i <= int'(ridx)) begin
            rs_d[i] = '{pos: 1'b0, neg: 1'b0, viol: 1'b0};
          end
        end
      end
      // oldest slot of the window leaves as a tributary bit
      out_slot = rs_d[ridx];
      rx_bit_d = out_slot.pos | out_slot.neg;
      rx_valid_d = 1'b1;
      err_pulse_d = out_slot.viol;
      // line zero run longer than the code allows also marks a bad line
      if (pulse || dual) begin
        rzc_d = 4'h0;
      end else if (rzc_q != blc_pkg::BLC_RUN_MAX) begin
        rzc_d = rzc_q + 4'h1;
      end
      zero_run_err_d = (rzc_d == zmax + 4'h1) && (zmax != blc_pkg::BLC_RUN_MAX);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rs_q <= '{default: '{pos: 1'b0, neg: 1'b0, viol: 1'b0}};
      rpol_q <= 1'b0;
      rseen_q <= 1'b0;
      rzc_q <= 4'h0;
      rx_bit_q <= 1'b0;
      rx_valid_q <= 1'b0;
      err_pulse_q <= 1'b0;
      zero_run_err_q <= 1'b0;
    end else if (ce) begin
      rs_q <= rs_d;
      rpol_q <= rpol_d;
      rseen_q <= rseen_d;
      rzc_q <= rzc_d;
      rx_bit_q <= rx_bit_d;
      rx_valid_q <= rx_valid_d;
      err_pulse_q <= err_pulse_d;
      zero_run_err_q <= zero_run_err_d;
    end
  end

  // ==========================================================
  // violation counter
  // saturates rather than wraps so a long outage never reads as clean;
  // an error in the clearing cycle is kept as the first new count
  logic [CNT_W-1:0] err_count_d;

  always_comb begin
    err_count_d = err_count_q;
    if (err_clr) begin
      err_count_d = err_pulse_d ? CNT_W'(1) : '0;
    end else if (err_pulse_d && err_count_q != {CNT_W{1'b1}}) begin
      err_count_d = err_count_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_count_q <= '0;
    end else if (ce) begin
      err_count_q <= err_count_d;
    end
  end

endmodule // blc_line_codec

`default_nettype wire

// File: bench/blc_line_unit.sv
// Purpose: line interface model that loops each tx symbol into an rx interval
// Assumes: one rx interval one cycle after every accepted tx strobe
// Notes: off-strobe rails invert their previous value every cycle, never a held value
`timescale 1ns/1ns
`default_nettype none

module blc_line_unit (
  // clock
  input wire logic clock,
  // codec transmit side and fault request
  input wire logic tx_stb,
  input wire blc_pkg::blc_line_t tx_line,
  input wire logic both,
  // codec receive side
  output logic rx_stb,
  output blc_pkg::blc_line_t rx_line
);
  logic pend_q = 1'b0;
  logic bad_q = 1'b0;

  initial begin
    rx_stb = 1'b0;
    rx_line = 2'b00;
  end
  always @(posedge clock) begin
    pend_q <= tx_stb;
    bad_q <= both & tx_stb;
  end
  // both rails at once is the only fault the bench asks for
  always @(negedge clock) begin
    rx_stb <= pend_q;
    rx_line <= pend_q ? (bad_q ? 2'b11 : tx_line) : ~rx_line;
  end
endmodule // blc_line_unit

`default_nettype wire

// File: bench/blc_line_codec_chk.sv
// Purpose: port checker for the bipolar line codec
// Assumes: one clock domain, mode held static between resets
// Notes: zero runs are counted once per accepted transmit strobe
`timescale 1ns/1ns
`default_nettype none

module blc_line_codec_chk #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // transmit
  input wire blc_pkg::blc_mode_t mode,
  input wire logic tx_bit_en,
  input wire blc_pkg::blc_line_t line_tx_q,
  // receive and link quality
  input wire logic rx_bit_en,
  input wire logic rx_valid_q,
  input wire logic err_clr,
  input wire logic [CNT_W-1:0] err_count_q,
  input wire logic err_pulse_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // zero intervals since the last pulse; plain AMI wraps, so it is never limited
  logic seen_q, seen_d;
  logic [3:0] zrun_q, zrun_d, lim;
  always_comb begin
    seen_d = tx_bit_en & ce;
    zrun_d = zrun_q;
    if (seen_q) begin
      zrun_d = (line_tx_q == 2'b00) ? zrun_q + 4'h1 : 4'h0;
    end
    lim = 4'hF;
    if (mode == blc_pkg::BLC_MODE_E1_HDB3 || mode == blc_pkg::BLC_MODE_E3_HDB3) begin
      lim = blc_pkg::BLC_ZMAX_HDB3;
    end else if (mode == blc_pkg::BLC_MODE_T3_B3ZS) begin
      lim = blc_pkg::BLC_ZMAX_B3ZS;
    end else if (mode == blc_pkg::BLC_MODE_T1_B8ZS) begin
      lim = blc_pkg::BLC_ZMAX_B8ZS;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seen_q <= 1'b0;
      zrun_q <= 4'h0;
    end else begin
      seen_q <= seen_d;
      zrun_q <= zrun_d;
    end
  end

  // ==========================================================
  // properties
  a_zero_run_max: assert property (zrun_q <= lim)
    else $error("zero run too long on line");
  a_no_both_rails: assert property (!(line_tx_q.pos && line_tx_q.neg))
    else $error("both rails driven");
  a_tx_holds: assert property (!$past(tx_bit_en && ce) |-> $stable(line_tx_q))
    else $error("line symbol moved without strobe");
  a_valid_follows: assert property (rx_bit_en && ce |=> rx_valid_q)
    else $error("no valid after rx strobe");
  a_valid_cause: assert property ($past(ce) && !$past(rx_bit_en) |-> !rx_valid_q)
    else $error("valid without rx strobe");
  a_err_in_valid: assert property (err_pulse_q |-> rx_valid_q)
    else $error("error pulse outside valid");
  a_count_hold: assert property (
    !err_pulse_q && !$past(err_clr && ce) |-> $stable(err_count_q))
    else $error("error count moved alone");
  a_count_step: assert property (
    $past(ce) && err_pulse_q && !$past(err_clr) && $past(err_count_q) != '1
    |-> err_count_q == $past(err_count_q) + 1'b1)
    else $error("error count did not step");
  a_count_sat: assert property (
    $past(ce) && err_pulse_q && !$past(err_clr) && $past(err_count_q) == '1 |-> err_count_q == '1)
    else $error("error count wrapped");
  a_clear_wins: assert property ($past(err_clr && ce) |-> err_count_q == CNT_W'(err_pulse_q))
    else $error("clear gave wrong count");
endmodule // blc_line_codec_chk

`default_nettype wire

// File: bench/testbench.sv
// Purpose: loopback bench for the bipolar line codec in every mode
// Assumes: partner returns each tx symbol as an rx interval a cycle later
// Notes: counter narrowed to 3 bits so saturation is reached quickly
`timescale 1ns/1ns
`default_nettype none

module testbench;
  localparam int unsigned CNT_W = 3;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic tx_bit_en = 1'b0;
  logic tx_bit = 1'b0;
  logic err_clr = 1'b0;
  logic both = 1'b0;
  logic tx_seen = 1'b0;
  blc_pkg::blc_mode_t mode = blc_pkg::BLC_MODE_E1_HDB3;
  logic rx_bit_en, rx_bit_q, rx_valid_q, err_pulse_q, zero_run_err_q;
  blc_pkg::blc_line_t line_tx_q, line_rx;
  logic [15:0] rate_kbps_q;
  logic [CNT_W-1:0] err_count_q;
  logic [2:0] te;
  logic [2:0] re;
  logic [2:0] txq[$];
  logic [2:0] rxq[$];
  logic hist[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int n, span;
  blc_pkg::blc_mode_t md[5] = '{blc_pkg::BLC_MODE_E1_HDB3, blc_pkg::BLC_MODE_T1_B8ZS,
    blc_pkg::BLC_MODE_T1_AMI, blc_pkg::BLC_MODE_E3_HDB3, blc_pkg::BLC_MODE_T3_B3ZS};
  logic [15:0] rt[5] = '{16'h0800, 16'h0608, 16'h0608, 16'h8640, 16'hAEC0};
  int ln[5] = '{4, 8, 1, 4, 3};
  string bs[5] = '{"1000000001", "1000000001", "110100001", "1000000001", "10000001"};
  string ss[5] = '{"+000+-00-+", "+000+-0-+-", "+-0+0000-", "+000+-00-+", "+00+-0-+"};

  blc_line_codec #(.CNT_W(CNT_W)) blc_line_codec_inst (
    .clock(clock), .rst(rst), .ce(ce), .mode(mode), .rate_kbps_q(rate_kbps_q),
    .tx_bit_en(tx_bit_en), .tx_bit(tx_bit), .line_tx_q(line_tx_q), .rx_bit_en(rx_bit_en),
    .line_rx(line_rx), .rx_bit_q(rx_bit_q), .rx_valid_q(rx_valid_q), .err_clr(err_clr),
    .err_count_q(err_count_q), .err_pulse_q(err_pulse_q), .zero_run_err_q(zero_run_err_q));
  blc_line_unit blc_line_unit_inst (
    .clock(clock), .tx_stb(tx_bit_en & ce), .tx_line(line_tx_q), .both(both),
    .rx_stb(rx_bit_en), .rx_line(line_rx));

  initial begin
    forever #25 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ce only drops from the third idle cycle on, when no result is in flight
  task automatic send(input logic b, input logic [2:0] tx_exp, input logic inj);
    int g;
    g = $urandom_range(4);
    hist.push_back(b);
    txq.push_back(tx_exp);
    // an injected fault shows with this same result only when span is zero (plain AMI)
    rxq.push_back((n >= 2 * span) ? {1'b1, hist[n - 2 * span], inj} : 3'b000);
    n++;
    ce <= 1'b1;
    tx_bit <= b;
    tx_bit_en <= 1'b1;
    both <= inj;
    @(negedge clock);
    // back to back strobes keep the strobe up, never drop and raise it in one step
    if (g > 0) begin
      tx_bit_en <= 1'b0;
      tx_bit <= 1'($urandom);
      both <= 1'b0;
    end
    for (int j = 0; j < g; j++) begin
      if (j > 1) ce <= ($urandom_range(3) != 0);
      @(negedge clock);
    end
  endtask

  // end a burst: strobe down and clock running again before counts are read
  task automatic rest();
    ce <= 1'b1;
    tx_bit_en <= 1'b0;
    both <= 1'b0;
    repeat (4) @(negedge clock);
  endtask

  // ==========================================================
  // monitors
  always @(posedge clock) tx_seen <= tx_bit_en & ce;
  always @(negedge clock) begin
    if (tx_seen && txq.size() > 0) begin
      te = txq.pop_front();
      if (te[2]) chk(16'(line_tx_q), 16'(te[1:0]));
    end
    if (rx_valid_q && rxq.size() > 0) begin
      re = rxq.pop_front();
      if (re[2]) chk(16'({rx_bit_q, err_pulse_q, zero_run_err_q}), 16'({re[1:0], 1'b0}));
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(15376));
    for (int i = 0; i < 5; i++) begin
      rst <= 1'b1;
      ce <= 1'b1;
      mode <= md[i];
      span = ln[i] - 1;
      n = 0;
      hist.delete();
      txq.delete();
      rxq.delete();
      repeat (span) txq.push_back(3'b000);
      repeat (16) @(negedge clock);
      rst <= 1'b0;
      repeat (3) @(negedge clock);
      chk(rate_kbps_q, rt[i]);
      for (int j = 0; j < bs[i].len(); j++) begin
        send(bs[i][j] == "1", {1'b1, ss[i][j] == "+", ss[i][j] == "-"}, 1'b0);
      end
      for (int j = 0; j < 300; j++) begin
        send((i == 2) ? ((n % 8 == 0) | 1'($urandom)) : ($urandom_range(2) == 0), 3'b000, 1'b0);
      end
      rest();
      chk(16'(err_count_q), 16'h0000);
      if (i == 2) begin
        // both rails on each zero before j reaches 19: each result is still compared, error flag included
        for (int j = 0; j < 40; j++) begin
          send(j % 2 == 0, 3'b000, (j % 2 == 1) && (j < 19));
        end
        rest();
        chk(16'(err_count_q), 16'((1 << CNT_W) - 1));
        err_clr <= 1'b1;
        @(negedge clock);
        err_clr <= 1'b0;
        @(negedge clock);
        chk(16'(err_count_q), 16'h0000);
      end
    end
    final_report();
  end

  // hang guard, far beyond the longest legal run
  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end
endmodule // testbench

bind blc_line_codec blc_line_codec_chk #(.CNT_W(CNT_W)) blc_line_codec_chk_inst (
  .clock(clock), .rst(rst), .ce(ce), .mode(mode), .tx_bit_en(tx_bit_en), .line_tx_q(line_tx_q),
  .rx_bit_en(rx_bit_en), .rx_valid_q(rx_valid_q), .err_clr(err_clr), .err_count_q(err_count_q),
  .err_pulse_q(err_pulse_q));

`default_nettype wire
